// ### vr_cond_consts.vh
// constants of the reluctance sensor conditioner control block
`ifndef VR_COND_CONSTS_VH
`define VR_COND_CONSTS_VH

// --------------------------------------------------------------
// register field positions
// --------------------------------------------------------------
`define MISC_AUTO_BIT 7
`define MISC_DISABLE_BIT 6
`define MISC_LOWREF_BIT 4
`define MISC_DEGLITCH_BIT 3
`define MISC_SINGLE_BIT 2
`define MISC_SWAP_BIT 1
`define MISC_DETACH_BIT 0
`define PARAM_THR_HI 7
`define PARAM_THR_LO 4
`define PARAM_BLANK_HI 3
`define PARAM_BLANK_LO 0
`define AUTO_MANT_HI 7
`define AUTO_MANT_LO 4
`define AUTO_EXP_HI 3
`define AUTO_EXP_LO 0

// --------------------------------------------------------------
// reset values and codes
// --------------------------------------------------------------
`define RUN_PARAMS_RST 8'h53
`define CRANK_PARAMS_RST 8'h00
`define AUTO_PARAMS_RST 8'h21
`define MISC_PARAMS_RST 8'h00
`define PEAK_RST 4'h0
`define THR_CEILING 4'hF
`define CRANK_EMPTY 8'h00

// --------------------------------------------------------------
// scaling and timing
// --------------------------------------------------------------
`define CNT_W 20
`define CNT_MAX 20'hFFFFF
`define BLANK_SHIFT 5
`define DEGLITCH_MUL 6'h29
`define DEGLITCH_SHIFT 12
`define CLK_PERIOD_NS 50
`define DECAY_TICK_NS 1000
`define DECAY_TICK_CYC ((`DECAY_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### sync2.v
// two flip-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module sync2 #(
	parameter W = 1
) (
	input wire clk_sys,
	input wire resetn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_r;

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ### span_timer.v
// down counter that stays busy for a loaded number of cycles
`default_nettype none
`include "vr_cond_consts.vh"
module span_timer (
	input wire clk_sys,
	input wire resetn,
	input wire clear,
	input wire start,
	input wire [`CNT_W-1:0] len,
	output wire busy
);
	reg [`CNT_W-1:0] cnt_r;

	assign busy = (cnt_r != {`CNT_W{1'b0}});

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			cnt_r <= {`CNT_W{1'b0}};
		else if (clear)
			cnt_r <= {`CNT_W{1'b0}};
		else if (start)
			cnt_r <= len;
		else if (busy)
			cnt_r <= cnt_r - 1'b1;
	end
endmodule
`default_nettype wire

// ### reluctance_sensor_conditioner_ctrl.v
// control and status logic of a variable reluctance sensor conditioner
// Summary of operation
// - blank output after each pulse by code/32 of last reference period
// - miscellaneous bit 7 selects manual or automatic threshold selection
// - manual mode holds threshold at the active parameter code
// - automatic mode jumps threshold to ceiling on every zero crossing
// - automatic mode steps threshold down to target at mantissa/exponent rate
// - disable bit turns conditioning off; reset value keeps it active
// - reference bit selects low pulse timing instead of high pulse
// - deglitch filters both edges with about 1% of last period
// - miscellaneous bit 3 enables deglitch; off after reset
// - single-ended bit wires sensor between positive input and ground
// - swap bit exchanges positive and negative inputs, inverting comparator and zero-cross levels
// - detach bit disconnects internal common-mode reference from both inputs
// - positive peak digitised to 4-bit code in status bits 7..4
// - peak code holds last peak; zero only after power-on or soft reset
// - two flags report positive and negative clamp reached
// - zero cranking register selects running register, else cranking register
// - comparator threshold code is bits 7..4 of active register
`default_nettype none
`include "vr_cond_consts.vh"
module reluctance_sensor_conditioner_ctrl (
	input wire clk_sys,
	input wire resetn,
	input wire soft_reset,
	input wire [7:0] run_params,
	input wire [7:0] crank_params,
	input wire [7:0] auto_params,
	input wire [7:0] misc_params,
	input wire comp_raw,
	input wire polarity_raw,
	input wire [3:0] peak_level_raw,
	input wire peak_toggle_raw,
	input wire clamp_pos_raw,
	input wire clamp_neg_raw,
	output reg [3:0] threshold_code,
	output reg conditioning_off,
	output reg swap_inputs,
	output reg single_ended_select,
	output reg common_ref_detach,
	output reg digitized_tooth_out,
	output reg [3:0] peak_status,
	output reg clamp_pos_flag,
	output reg clamp_neg_flag
);
	// --------------------------------------------------------------
	// state encodings
	// --------------------------------------------------------------
	localparam [2:0] ST_MANUAL = 3'b001;
	localparam [2:0] ST_DECAY = 3'b010;
	localparam [2:0] ST_SETTLED = 3'b100;
	localparam integer TICK_LAST_I = `DECAY_TICK_CYC - 1;
	localparam [4:0] TICK_LAST = TICK_LAST_I[4:0];

	// --------------------------------------------------------------
	// synchronised analogue-side inputs
	// --------------------------------------------------------------
	wire [8:0] sync_q;
	wire comp_s;
	wire pol_s;
	wire clamp_pos_s;
	wire clamp_neg_s;
	wire peak_tog_s;
	wire [3:0] peak_lvl_s;

	sync2 #(
		.W(9)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.d({peak_level_raw, peak_toggle_raw, clamp_neg_raw, clamp_pos_raw, polarity_raw, comp_raw}),
		.q(sync_q)
	);

	assign comp_s = sync_q[0];
	assign pol_s = sync_q[1];
	assign clamp_pos_s = sync_q[2];
	assign clamp_neg_s = sync_q[3];
	assign peak_tog_s = sync_q[4];
	assign peak_lvl_s = sync_q[8:5];

	// --------------------------------------------------------------
	// configuration decode
	// --------------------------------------------------------------
	wire auto_mode;
	wire disabled;
	wire low_ref;
	wire deglitch_en;
	wire [7:0] active_params;
	wire [3:0] thr_target;
	wire [3:0] blank_code;
	wire [3:0] mant_raw;
	wire [3:0] mant_eff;
	wire [3:0] exp_code;

	assign auto_mode = misc_params[`MISC_AUTO_BIT];
	assign disabled = misc_params[`MISC_DISABLE_BIT];
	assign low_ref = misc_params[`MISC_LOWREF_BIT];
	assign deglitch_en = misc_params[`MISC_DEGLITCH_BIT];
	assign active_params = (crank_params == `CRANK_EMPTY) ? run_params : crank_params;
	assign thr_target = active_params[`PARAM_THR_HI:`PARAM_THR_LO];
	assign blank_code = active_params[`PARAM_BLANK_HI:`PARAM_BLANK_LO];
	assign mant_raw = auto_params[`AUTO_MANT_HI:`AUTO_MANT_LO];
	assign mant_eff = (mant_raw == 4'h0) ? 4'h1 : mant_raw;
	assign exp_code = auto_params[`AUTO_EXP_HI:`AUTO_EXP_LO];

	// --------------------------------------------------------------
	// pin option outputs
	// --------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			conditioning_off <= 1'b0;
			swap_inputs <= 1'b0;
			single_ended_select <= 1'b0;
			common_ref_detach <= 1'b0;
		end
		else
		begin
			conditioning_off <= disabled;
			swap_inputs <= misc_params[`MISC_SWAP_BIT];
			single_ended_select <= misc_params[`MISC_SINGLE_BIT];
			common_ref_detach <= misc_params[`MISC_DETACH_BIT];
		end
	end

	// --------------------------------------------------------------
	// reference period measurement
	// --------------------------------------------------------------
	reg [`CNT_W-1:0] period_cnt_r;
	reg [`CNT_W-1:0] period_r;
	reg ref_d_r;
	wire ref_level;
	wire ref_end;

	assign ref_level = digitized_tooth_out ^ low_ref;
	assign ref_end = ref_d_r & ~ref_level;

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			period_cnt_r <= {`CNT_W{1'b0}};
			period_r <= {`CNT_W{1'b0}};
			ref_d_r <= 1'b0;
		end
		else if (soft_reset || disabled)
		begin
			period_cnt_r <= {`CNT_W{1'b0}};
			period_r <= {`CNT_W{1'b0}};
			ref_d_r <= 1'b0;
		end
		else
		begin
			ref_d_r <= ref_level;
			if (ref_end)
			begin
				period_r <= period_cnt_r;
				period_cnt_r <= {`CNT_W{1'b0}};
			end
			else if (ref_level && period_cnt_r != `CNT_MAX)
				period_cnt_r <= period_cnt_r + 1'b1;
		end
	end

	// --------------------------------------------------------------
	// scaled durations
	// --------------------------------------------------------------
	wire [23:0] blank_prod;
	wire [25:0] dg_prod;
	wire [`CNT_W-1:0] blank_len;
	wire [`CNT_W-1:0] dg_len;
	wire [`CNT_W-1:0] blank_base;

	// high reference: the pulse that is just ending is still in the running count
	assign blank_base = low_ref ? period_r : period_cnt_r;
	assign blank_prod = blank_base * blank_code;
	assign blank_len = {1'b0, blank_prod[23:`BLANK_SHIFT]};
	assign dg_prod = period_r * `DEGLITCH_MUL;
	assign dg_len = {6'h00, dg_prod[25:`DEGLITCH_SHIFT]};

	// --------------------------------------------------------------
	// deglitch filter
	// --------------------------------------------------------------
	reg filt_r;
	reg dg_pend_r;
	wire mismatch;
	wire dg_busy;
	wire dg_start;

	assign mismatch = comp_s ^ filt_r;
	assign dg_start = deglitch_en & mismatch & ~dg_pend_r;

	span_timer u_deglitch (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clear(soft_reset | disabled | ~mismatch),
		.start(dg_start),
		.len(dg_len),
		.busy(dg_busy)
	);

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			filt_r <= 1'b0;
			dg_pend_r <= 1'b0;
		end
		else if (soft_reset || disabled)
		begin
			filt_r <= 1'b0;
			dg_pend_r <= 1'b0;
		end
		else if (!deglitch_en)
		begin
			filt_r <= comp_s;
			dg_pend_r <= 1'b0;
		end
		else if (!mismatch)
			dg_pend_r <= 1'b0;
		else if (!dg_pend_r)
			dg_pend_r <= 1'b1;
		else if (!dg_busy)
		begin
			filt_r <= comp_s;
			dg_pend_r <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// blanking one shot and conditioned output
	// --------------------------------------------------------------
	wire blank_busy;
	wire pulse_end;

	assign pulse_end = digitized_tooth_out & ~filt_r;

	span_timer u_blank (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clear(soft_reset | disabled),
		.start(pulse_end),
		.len(blank_len),
		.busy(blank_busy)
	);

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			digitized_tooth_out <= 1'b0;
		else if (soft_reset || disabled)
			digitized_tooth_out <= 1'b0;
		else if (!blank_busy && !pulse_end)
			digitized_tooth_out <= filt_r;
		else if (pulse_end)
			digitized_tooth_out <= 1'b0;
	end

	// --------------------------------------------------------------
	// threshold selection and automatic decay
	// --------------------------------------------------------------
	reg [2:0] thr_state_r;
	reg [2:0] thr_state_nxt;
	reg [3:0] thr_nxt;
	reg pol_d_r;
	reg [4:0] tick_cnt_r;
	reg [`CNT_W-1:0] step_cnt_r;
	wire zero_cross;
	wire tick;
	wire step_due;
	wire [`CNT_W-1:0] decay_len;

	assign zero_cross = pol_s ^ pol_d_r;
	assign tick = (tick_cnt_r == TICK_LAST);
	assign decay_len = {16'h0000, mant_eff} << exp_code;
	assign step_due = tick & (step_cnt_r + 1'b1 >= decay_len);

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pol_d_r <= 1'b0;
			tick_cnt_r <= 5'h00;
		end
		else
		begin
			pol_d_r <= pol_s;
			tick_cnt_r <= tick ? 5'h00 : tick_cnt_r + 1'b1;
		end
	end

	always @*
	begin
		thr_state_nxt = thr_state_r;
		thr_nxt = threshold_code;
		case (thr_state_r)
			ST_MANUAL:
			begin
				thr_nxt = thr_target;
				if (auto_mode && zero_cross)
				begin
					thr_nxt = `THR_CEILING;
					thr_state_nxt = ST_DECAY;
				end
			end
			ST_DECAY:
			begin
				if (step_due)
				begin
					if (threshold_code > thr_target)
						thr_nxt = threshold_code - 1'b1;
					else
					begin
						thr_nxt = thr_target;
						thr_state_nxt = ST_SETTLED;
					end
				end
			end
			ST_SETTLED:
				thr_nxt = thr_target;
			default:
			begin
				thr_nxt = thr_target;
				thr_state_nxt = ST_MANUAL;
			end
		endcase
		if (!auto_mode)
		begin
			thr_nxt = thr_target;
			thr_state_nxt = ST_MANUAL;
		end
		else if (zero_cross)
		begin
			thr_nxt = `THR_CEILING;
			thr_state_nxt = ST_DECAY;
		end
	end

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			thr_state_r <= ST_MANUAL;
			threshold_code <= 4'h5;
			step_cnt_r <= {`CNT_W{1'b0}};
		end
		else if (soft_reset)
		begin
			thr_state_r <= ST_MANUAL;
			threshold_code <= thr_target;
			step_cnt_r <= {`CNT_W{1'b0}};
		end
		else
		begin
			thr_state_r <= thr_state_nxt;
			threshold_code <= thr_nxt;
			if (zero_cross || step_due || thr_state_r != ST_DECAY)
				step_cnt_r <= {`CNT_W{1'b0}};
			else if (tick)
				step_cnt_r <= step_cnt_r + 1'b1;
		end
	end

	// --------------------------------------------------------------
	// peak and clamp status
	// --------------------------------------------------------------
	reg peak_tog_d_r;

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			peak_tog_d_r <= 1'b0;
			peak_status <= `PEAK_RST;
			clamp_pos_flag <= 1'b0;
			clamp_neg_flag <= 1'b0;
		end
		else
		begin
			peak_tog_d_r <= peak_tog_s;
			clamp_pos_flag <= clamp_pos_s;
			clamp_neg_flag <= clamp_neg_s;
			if (soft_reset)
				peak_status <= `PEAK_RST;
			else if (peak_tog_s ^ peak_tog_d_r)
				peak_status <= peak_lvl_s;
		end
	end
endmodule
`default_nettype wire

// ### vr_cond_sva.sv
// assertions on the ports of the sensor conditioner control block
`default_nettype none
module vr_cond_sva (
	input wire clk_sys,
	input wire resetn,
	input wire soft_reset,
	input wire [7:0] run_params,
	input wire [7:0] crank_params,
	input wire [7:0] auto_params,
	input wire [7:0] misc_params,
	input wire comp_raw,
	input wire polarity_raw,
	input wire [3:0] peak_level_raw,
	input wire peak_toggle_raw,
	input wire clamp_pos_raw,
	input wire clamp_neg_raw,
	input wire [3:0] threshold_code,
	input wire conditioning_off,
	input wire swap_inputs,
	input wire single_ended_select,
	input wire common_ref_detach,
	input wire digitized_tooth_out,
	input wire [3:0] peak_status,
	input wire clamp_pos_flag,
	input wire clamp_neg_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [7:0] act = (crank_params != 8'h00) ? crank_params : run_params;
	wire [1:0] cl = {clamp_pos_raw, clamp_neg_raw};
	wire [1:0] fl = {clamp_pos_flag, clamp_neg_flag};
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ------
	// checks
	// ------
	manual_thr_a: assert property ((!misc_params[7] && $stable(act)) [*3] |-> threshold_code == act[7:4])
		else $error("manual threshold wrong");
	auto_ceil_a: assert property (misc_params[7] && $changed(polarity_raw) |-> ##[1:5] threshold_code == 4'hF)
		else $error("no jump to ceiling");
	auto_step_a: assert property (misc_params[7] && $past(misc_params[7]) && !$past(soft_reset)
		&& threshold_code < $past(threshold_code) |-> threshold_code == $past(threshold_code) - 4'h1)
		else $error("decay step wrong");
	dis_out_a: assert property (conditioning_off [*3] |-> !digitized_tooth_out)
		else $error("output active while off");
	opt_copy_a: assert property ($past(resetn) |-> {conditioning_off, swap_inputs, single_ended_select,
		common_ref_detach} == $past({misc_params[6], misc_params[1], misc_params[2], misc_params[0]}))
		else $error("option outputs wrong");
	peak_hold_a: assert property (peak_status != $past(peak_status) && !$past(soft_reset) && !$past(soft_reset, 2)
		|-> $past(peak_toggle_raw, 2) != $past(peak_toggle_raw, 7))
		else $error("peak changed without peak");
	peak_clr_a: assert property (soft_reset |-> ##[1:2] peak_status == 4'h0)
		else $error("peak not cleared");
	peak_code_a: assert property ($changed(peak_toggle_raw) |-> ##[2:6] peak_status == peak_level_raw)
		else $error("peak code wrong");
	clamp_lat_a: assert property ($changed(cl) ##1 $stable(cl) [*4] |-> fl == cl)
		else $error("clamp flags wrong");
	cover property (digitized_tooth_out ##1 !digitized_tooth_out);
	cover property (threshold_code == 4'hF ##1 threshold_code == 4'hE);
	cover property (soft_reset ##2 peak_status == 4'h0);
endmodule
bind reluctance_sensor_conditioner_ctrl vr_cond_sva chk (.clk_sys, .resetn, .soft_reset, .run_params,
	.crank_params, .auto_params, .misc_params, .comp_raw, .polarity_raw, .peak_level_raw, .peak_toggle_raw,
	.clamp_pos_raw, .clamp_neg_raw, .threshold_code, .conditioning_off, .swap_inputs, .single_ended_select,
	.common_ref_detach, .digitized_tooth_out, .peak_status, .clamp_pos_flag, .clamp_neg_flag);
`default_nettype wire

// ### vr_sensor_model.sv
// behavioural crank sensor with comparator, zero-cross and peak detector
`default_nettype none
module vr_sensor_model (
	input wire clk_sys,
	input wire run,
	input wire glitch,
	input wire swap_inputs,
	input wire [3:0] peak_in,
	input wire [1:0] clamp_in,
	output logic comp_raw,
	output logic polarity_raw,
	output logic [3:0] peak_level_raw,
	output logic peak_toggle_raw,
	output logic clamp_pos_raw,
	output logic clamp_neg_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HI = 400;
	localparam int LO = 200;
	localparam int GAP = 75;
	int t = 0;
	initial
	begin
		peak_level_raw = 4'h0;
		peak_toggle_raw = 1'b0;
	end
	always @(posedge clk_sys)
	begin
		if (run)
		begin
			t <= (t == HI + LO - 1) ? 0 : t + 1;
			if (t == 0)
				peak_level_raw <= peak_in;
			if (t == HI / 2)
				peak_toggle_raw <= ~peak_toggle_raw;
		end
	end
	// swapped inputs invert the comparator and zero-cross levels seen by the block; clamp levels pass unchanged
	assign comp_raw = swap_inputs ^ (run && (t < HI || (glitch && t >= HI + GAP && t < HI + GAP + 2)));
	assign polarity_raw = swap_inputs ^ (run && t < HI);
	assign clamp_pos_raw = clamp_in[1];
	assign clamp_neg_raw = clamp_in[0];
endmodule
`default_nettype wire

// ### tb_reluctance_sensor_conditioner_ctrl.sv
// self-checking bench for the sensor conditioner control block
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_reluctance_sensor_conditioner_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic soft_reset = 1'b0;
	logic [7:0] run_params = 8'h53;
	logic [7:0] crank_params = 8'h00;
	logic [7:0] auto_params = 8'h21;
	logic [7:0] misc_params = 8'h00;
	logic run = 1'b0;
	logic glitch = 1'b0;
	logic [3:0] peak_in = 4'h0;
	logic [1:0] clamp_in = 2'b00;
	wire comp_raw, polarity_raw, peak_toggle_raw, clamp_pos_raw, clamp_neg_raw;
	wire [3:0] peak_level_raw, threshold_code, peak_status;
	wire conditioning_off, swap_inputs, single_ended_select, common_ref_detach;
	wire digitized_tooth_out, clamp_pos_flag, clamp_neg_flag;
	wire [3:0] opts = {conditioning_off, swap_inputs, single_ended_select, common_ref_detach};
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int k;
	int cnt;
	always #25 clk_sys = ~clk_sys;
	reluctance_sensor_conditioner_ctrl dut (.clk_sys, .resetn, .soft_reset, .run_params, .crank_params,
		.auto_params, .misc_params, .comp_raw, .polarity_raw, .peak_level_raw, .peak_toggle_raw, .clamp_pos_raw,
		.clamp_neg_raw, .threshold_code, .conditioning_off, .swap_inputs, .single_ended_select,
		.common_ref_detach, .digitized_tooth_out, .peak_status, .clamp_pos_flag, .clamp_neg_flag);
	vr_sensor_model sensor (.clk_sys, .run, .glitch, .swap_inputs, .peak_in, .clamp_in, .comp_raw,
		.polarity_raw, .peak_level_raw, .peak_toggle_raw, .clamp_pos_raw, .clamp_neg_raw);
	// -----
	// tasks
	// -----
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic cfg(input logic [7:0] m, input logic [7:0] r, input logic [7:0] c);
		@(posedge clk_sys);
		misc_params <= m;
		run_params <= r;
		crank_params <= c;
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// counts output rising edges over four teeth with a glitch in each low phase
	task automatic edges(input logic [7:0] m, input logic [7:0] r, input int exp);
		int e;
		logic p;
		e = 0;
		cfg(m, r, 8'h00);
		tick(1200);
		#1;
		p = digitized_tooth_out;
		repeat (2400)
		begin
			@(posedge clk_sys);
			#1;
			if (p === 1'b0 && digitized_tooth_out === 1'b1)
				e++;
			p = digitized_tooth_out;
		end
		`CHK("rising edges", exp, e)
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			finish_test;
		end
	end
	initial
	begin
		tick(16);
		resetn <= 1'b1;
		tick(3);
		`CHK("threshold", 4'h5, threshold_code);
		`CHK("peak", 4'h0, peak_status);
		`CHK("options", 4'h0, opts);
		cfg(8'h00, 8'h53, 8'hA0);
		tick(4);
		`CHK("crank threshold", 4'hA, threshold_code);
		cfg(8'h00, 8'h53, 8'h00);
		tick(4);
		`CHK("run threshold", 4'h5, threshold_code);
		cfg(8'h07, 8'h53, 8'h00);
		tick(3);
		`CHK("options", 4'h7, opts);
		cfg(8'h40, 8'h53, 8'h00);
		tick(3);
		`CHK("options", 4'h8, opts);
		cfg(8'h80, 8'hA0, 8'h00);
		auto_params <= 8'h10;
		run <= 1'b1;
		peak_in <= 4'hC;
		for (k = 0; k < 1000 && threshold_code !== 4'hF; k++)
			tick(1);
		for (cnt = 0; cnt < 1000 && threshold_code !== 4'hA; cnt++)
			tick(1);
		`CHK("decay span", 1'b1, cnt >= 78 && cnt <= 105);
		tick(600);
		`CHK("peak code", 4'hC, peak_status);
		cfg(8'h00, 8'hA0, 8'h00);
		run <= 1'b0;
		tick(1);
		soft_reset <= 1'b1;
		tick(1);
		soft_reset <= 1'b0;
		tick(700);
		`CHK("peak cleared", 4'h0, peak_status);
		clamp_in <= 2'b10;
		tick(6);
		`CHK("clamp flags", 2'b10, {clamp_pos_flag, clamp_neg_flag});
		clamp_in <= 2'b01;
		tick(6);
		`CHK("clamp flags", 2'b01, {clamp_pos_flag, clamp_neg_flag});
		run <= 1'b1;
		glitch <= 1'b1;
		edges(8'h00, 8'h50, 8);
		edges(8'h00, 8'h58, 4);
		edges(8'h10, 8'h58, 8);
		edges(8'h08, 8'h50, 4);
		edges(8'h40, 8'h50, 0);
		finish_test;
	end
endmodule
`default_nettype wire
